// ===== hw/aao_alu_core.sv
// Accumulator ALU operation sequencer with flags, write back and skip control
`timescale 1ns/100ps
`default_nettype none

module aao_alu_core
    import aao_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic op_valid,
    input wire aao_op_t op_code,
    input wire logic [7:0] mem_rdata,
    input wire logic [7:0] imm_data,
    input wire logic [2:0] bit_sel,
    output logic ready,
    output logic done,
    output logic [7:0] acc,
    output logic flag_c,
    output logic flag_ac,
    output logic flag_z,
    output logic flag_ov,
    output logic mem_wr,
    output logic [7:0] mem_wdata,
    output logic skip
);

    aao_state_t state;
    aao_state_t next_state;
    logic next_ready;
    logic next_done;
    logic [7:0] next_acc;
    logic next_flag_c;
    logic next_flag_ac;
    logic next_flag_z;
    logic next_flag_ov;
    logic next_mem_wr;
    logic [7:0] next_mem_wdata;
    logic next_skip;

    logic take;
    logic [7:0] rol;
    logic [7:0] ror;
    logic [7:0] rol_c;
    logic rol_cout;
    logic [7:0] ror_c;
    logic ror_cout;
    logic [7:0] swapped;
    logic [7:0] bit_set_val;
    logic [7:0] sub_opnd;
    logic sub_borrow_en;
    logic [7:0] diff;
    logic sub_c;
    logic sub_ac;
    logic sub_ov;
    logic [7:0] mem_inc;
    logic [7:0] mem_dec;

    ////////////////////////////////////////////////////////////////////////////
    // Datapath units

    aao_shift_unit u_shift (
        .opnd(mem_rdata),
        .carry_in(flag_c),
        .bit_sel(bit_sel),
        .rol(rol),
        .ror(ror),
        .rol_c(rol_c),
        .rol_cout(rol_cout),
        .ror_c(ror_c),
        .ror_cout(ror_cout),
        .swapped(swapped),
        .bit_set_val(bit_set_val)
    );

    // Immediate form takes the constant in place of the memory byte
    assign sub_opnd = (op_code == op_subtract_immediate) ? imm_data : mem_rdata;
    assign sub_borrow_en = (op_code == op_subtract_with_borrow)
        || (op_code == op_subtract_with_borrow_to_mem);

    aao_sub_unit u_sub (
        .minuend(acc),
        .subtrahend(sub_opnd),
        .with_borrow(sub_borrow_en),
        .carry_in(flag_c),
        .diff(diff),
        .carry_out(sub_c),
        .aux_out(sub_ac),
        .ovf_out(sub_ov)
    );

    assign mem_inc = mem_rdata + AAO_BYTE_ONE;
    assign mem_dec = mem_rdata - AAO_BYTE_ONE;

    // Requests are ignored during the dummy cycle
    assign take = op_valid && ready;

    ////////////////////////////////////////////////////////////////////////////
    // Next state and result computation

    always_comb
    begin
        next_state = state;
        next_ready = ready;
        next_done = 1'b0;
        next_acc = acc;
        next_flag_c = flag_c;
        next_flag_ac = flag_ac;
        next_flag_z = flag_z;
        next_flag_ov = flag_ov;
        next_mem_wr = 1'b0;
        next_mem_wdata = mem_wdata;
        next_skip = 1'b0;
        case (state)
            st_idle:
            begin
                if (take)
                begin
                    next_done = 1'b1;
                    case (op_code)
                        op_rotate_left_to_acc:
                        begin
                            next_acc = rol;
                        end
                        op_rotate_left_thru_carry:
                        begin
                            next_mem_wr = 1'b1;
                            next_mem_wdata = rol_c;
                            next_flag_c = rol_cout;
                        end
                        op_rotate_left_thru_carry_to_acc:
                        begin
                            next_acc = rol_c;
                            next_flag_c = rol_cout;
                        end
                        op_rotate_right_in_place:
                        begin
                            next_mem_wr = 1'b1;
                            next_mem_wdata = ror;
                        end
                        op_rotate_right_to_acc:
                        begin
                            next_acc = ror;
                        end
                        op_rotate_right_thru_carry:
                        begin
                            next_mem_wr = 1'b1;
                            next_mem_wdata = ror_c;
                            next_flag_c = ror_cout;
                        end
                        op_rotate_right_thru_carry_to_acc:
                        begin
                            next_acc = ror_c;
                            next_flag_c = ror_cout;
                        end
                        op_subtract_with_borrow, op_subtract_to_acc, op_subtract_immediate:
                        begin
                            next_acc = diff;
                            next_flag_c = sub_c;
                            next_flag_ac = sub_ac;
                            next_flag_z = aao_is_zero(diff);
                            next_flag_ov = sub_ov;
                        end
                        op_subtract_with_borrow_to_mem, op_minus_memory_into_memory:
                        begin
                            next_mem_wr = 1'b1;
                            next_mem_wdata = diff;
                            next_flag_c = sub_c;
                            next_flag_ac = sub_ac;
                            next_flag_z = aao_is_zero(diff);
                            next_flag_ov = sub_ov;
                        end
                        op_decrement_skip_if_zero:
                        begin
                            next_mem_wr = 1'b1;
                            next_mem_wdata = mem_dec;
                            next_skip = aao_is_zero(mem_dec);
                        end
                        op_decrement_to_acc_skip_if_zero:
                        begin
                            next_acc = mem_dec;
                            next_skip = aao_is_zero(mem_dec);
                        end
                        op_increment_skip_if_zero:
                        begin
                            next_mem_wr = 1'b1;
                            next_mem_wdata = mem_inc;
                            next_skip = aao_is_zero(mem_inc);
                        end
                        op_increment_to_acc_skip_if_zero:
                        begin
                            next_acc = mem_inc;
                            next_skip = aao_is_zero(mem_inc);
                        end
                        op_skip_if_bit_set:
                        begin
                            next_skip = mem_rdata[bit_sel];
                        end
                        op_skip_if_memory_zero:
                        begin
                            next_skip = aao_is_zero(mem_rdata);
                        end
                        op_byte_set:
                        begin
                            next_mem_wr = 1'b1;
                            next_mem_wdata = AAO_BYTE_ONES;
                        end
                        op_bit_set:
                        begin
                            next_mem_wr = 1'b1;
                            next_mem_wdata = bit_set_val;
                        end
                        op_nibble_exchange_in_place:
                        begin
                            next_mem_wr = 1'b1;
                            next_mem_wdata = swapped;
                        end
                        op_nibble_exchange_to_acc:
                        begin
                            next_acc = swapped;
                        end
                        op_load_acc:
                        begin
                            next_acc = imm_data;
                        end
                        op_load_carry:
                        begin
                            next_flag_c = imm_data[0];
                        end
                        default:
                        begin
                            next_done = 1'b0;
                        end
                    endcase
                    // Taken skip holds off the next request for the dummy cycle
                    if (next_skip)
                    begin
                        next_state = st_dummy;
                        next_ready = 1'b0;
                    end
                end
            end
            st_dummy:
            begin
                next_state = st_idle;
                next_ready = 1'b1;
            end
            default:
            begin
                next_state = st_idle;
                next_ready = 1'b1;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // State registers

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            state <= st_idle;
            ready <= 1'b1;
            done <= 1'b0;
            acc <= AAO_ACC_RESET;
            flag_c <= AAO_FLAG_RESET;
            flag_ac <= AAO_FLAG_RESET;
            flag_z <= AAO_FLAG_RESET;
            flag_ov <= AAO_FLAG_RESET;
            mem_wr <= 1'b0;
            mem_wdata <= AAO_BYTE_ZERO;
            skip <= 1'b0;
        end
        else
        begin
            state <= next_state;
            ready <= next_ready;
            done <= next_done;
            acc <= next_acc;
            flag_c <= next_flag_c;
            flag_ac <= next_flag_ac;
            flag_z <= next_flag_z;
            flag_ov <= next_flag_ov;
            mem_wr <= next_mem_wr;
            mem_wdata <= next_mem_wdata;
            skip <= next_skip;
        end
    end

endmodule

`default_nettype wire

// ===== hw/aao_pkg.sv
// Constants, opcodes and states shared by the accumulator ALU operation block
package aao_pkg;

    // Datapath widths and field positions
    localparam int AAO_MSB = 7;
    localparam int AAO_NIB_HI = 4;
    localparam int AAO_NIB_LO = 3;
    localparam int AAO_SEL_W = 3;

    // Constant byte values
    localparam logic [7:0] AAO_BYTE_ZERO = 8'h00;
    localparam logic [7:0] AAO_BYTE_ONES = 8'hff;
    localparam logic [7:0] AAO_BYTE_ONE = 8'h01;

    // Reset values
    localparam logic [7:0] AAO_ACC_RESET = 8'h00;
    localparam logic AAO_FLAG_RESET = 1'b0;

    // Operation codes presented on op_code
    typedef enum logic [4:0] {
        op_rotate_left_to_acc = 5'h00,
        op_rotate_left_thru_carry = 5'h01,
        op_rotate_left_thru_carry_to_acc = 5'h02,
        op_rotate_right_in_place = 5'h03,
        op_rotate_right_to_acc = 5'h04,
        op_rotate_right_thru_carry = 5'h05,
        op_rotate_right_thru_carry_to_acc = 5'h06,
        op_subtract_with_borrow = 5'h07,
        op_subtract_with_borrow_to_mem = 5'h08,
        op_subtract_to_acc = 5'h09,
        op_minus_memory_into_memory = 5'h0a,
        op_subtract_immediate = 5'h0b,
        op_decrement_skip_if_zero = 5'h0c,
        op_decrement_to_acc_skip_if_zero = 5'h0d,
        op_increment_skip_if_zero = 5'h0e,
        op_increment_to_acc_skip_if_zero = 5'h0f,
        op_skip_if_bit_set = 5'h10,
        op_skip_if_memory_zero = 5'h11,
        op_byte_set = 5'h12,
        op_bit_set = 5'h13,
        op_nibble_exchange_in_place = 5'h14,
        op_nibble_exchange_to_acc = 5'h15,
        op_load_acc = 5'h16,
        op_load_carry = 5'h17
    } aao_op_t;

    // Sequencer states, one-hot
    typedef enum logic [1:0] {
        st_idle = 2'h1,
        st_dummy = 2'h2
    } aao_state_t;

    // Zero test of a byte
    function automatic logic aao_is_zero(input logic [7:0] v);
        return (v == AAO_BYTE_ZERO);
    endfunction

endpackage

// ===== hw/aao_shift_unit.sv
// Rotate, nibble exchange and bit set paths of the ALU
`timescale 1ns/100ps
`default_nettype none

module aao_shift_unit
    import aao_pkg::*;
(
    input wire logic [7:0] opnd,
    input wire logic carry_in,
    input wire logic [2:0] bit_sel,
    output logic [7:0] rol,
    output logic [7:0] ror,
    output logic [7:0] rol_c,
    output logic rol_cout,
    output logic [7:0] ror_c,
    output logic ror_cout,
    output logic [7:0] swapped,
    output logic [7:0] bit_set_val
);

    logic [7:0] bit_mask;

    ////////////////////////////////////////////////////////////////////////////
    // Plain rotates, bit 7 and bit 0 wrap round
    assign rol = {opnd[AAO_MSB-1:0], opnd[AAO_MSB]};
    assign ror = {opnd[0], opnd[AAO_MSB:1]};

    ////////////////////////////////////////////////////////////////////////////
    // Rotates through carry, carry as ninth bit
    assign rol_c = {opnd[AAO_MSB-1:0], carry_in};
    assign rol_cout = opnd[AAO_MSB];
    assign ror_c = {carry_in, opnd[AAO_MSB:1]};
    assign ror_cout = opnd[0];

    ////////////////////////////////////////////////////////////////////////////
    // Nibble exchange and single bit set
    assign swapped = {opnd[AAO_NIB_LO:0], opnd[AAO_MSB:AAO_NIB_HI]};
    assign bit_mask = AAO_BYTE_ONE << bit_sel;
    assign bit_set_val = opnd | bit_mask;

endmodule

`default_nettype wire

// ===== hw/aao_sub_unit.sv
// Eight bit subtractor with borrow and status flag outputs
`timescale 1ns/100ps
`default_nettype none

module aao_sub_unit
    import aao_pkg::*;
(
    input wire logic [7:0] minuend,
    input wire logic [7:0] subtrahend,
    input wire logic with_borrow,
    input wire logic carry_in,
    output logic [7:0] diff,
    output logic carry_out,
    output logic aux_out,
    output logic ovf_out
);

    logic borrow;
    logic [8:0] full;
    logic [4:0] low;

    // Borrow is the inverse of carry, applied only when with_borrow is set
    assign borrow = with_borrow & ~carry_in;
    assign full = {1'b0, minuend} - {1'b0, subtrahend} - {8'h00, borrow};
    assign low = {1'b0, minuend[AAO_NIB_LO:0]} - {1'b0, subtrahend[AAO_NIB_LO:0]}
        - {4'h0, borrow};
    assign diff = full[AAO_MSB:0];
    // Carry clear on negative result, set on zero or positive
    assign carry_out = ~full[AAO_MSB+1];
    assign aux_out = ~low[AAO_NIB_HI];
    assign ovf_out = (minuend[AAO_MSB] ^ subtrahend[AAO_MSB])
        & (minuend[AAO_MSB] ^ full[AAO_MSB]);

endmodule

`default_nettype wire

// ===== verification/aao_alu_core_sva.sv
// Checker of handshake timing and results of the ALU operation core
`timescale 1ns/100ps
`default_nettype none
module aao_alu_core_sva
    import aao_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic op_valid,
    input wire aao_op_t op_code,
    input wire logic [7:0] mem_rdata,
    input wire logic [7:0] imm_data,
    input wire logic [2:0] bit_sel,
    input wire logic ready,
    input wire logic done,
    input wire logic [7:0] acc,
    input wire logic flag_c,
    input wire logic flag_ac,
    input wire logic flag_z,
    input wire logic flag_ov,
    input wire logic mem_wr,
    input wire logic [7:0] mem_wdata,
    input wire logic skip
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    logic take;
    assign take = op_valid && ready;
    a_done_after_take: assert property (take && op_code <= op_load_carry |=> done)
        else $error("done missing after a taken request");
    a_no_spurious_done: assert property (!take |=> !done)
        else $error("done without a taken request");
    a_skip_dummy_cycle: assert property (skip |-> done && !ready ##1 ready && !done)
        else $error("taken skip without one dummy cycle");
    a_rotate_left_acc: assert property (take && op_code == op_rotate_left_to_acc |=>
        acc == {$past(mem_rdata[6:0]), $past(mem_rdata[7])} && $stable(flag_c) && !mem_wr)
        else $error("rotate left to acc wrong");
    a_incr_skip_wrap: assert property (take && op_code == op_increment_skip_if_zero |=>
        mem_wr && mem_wdata == $past(mem_rdata) + 8'h01 && skip == ($past(mem_rdata) == 8'hff))
        else $error("increment skip wrong");
    a_sub_carry_sign: assert property (take && op_code == op_subtract_to_acc |=>
        flag_c == ($past(acc) >= $past(mem_rdata)))
        else $error("subtract carry wrong");
    a_bit_test_skip: assert property (take && op_code == op_skip_if_bit_set |=>
        skip == $past(mem_rdata[bit_sel]) && !mem_wr)
        else $error("bit test skip wrong");
    a_byte_set_ones: assert property (take && op_code == op_byte_set |=>
        mem_wr && mem_wdata == 8'hff && $stable(flag_z))
        else $error("byte set wrong");
    a_swap_to_acc: assert property (take && op_code == op_nibble_exchange_to_acc |=>
        acc == {$past(mem_rdata[3:0]), $past(mem_rdata[7:4])} && !mem_wr)
        else $error("nibble exchange to acc wrong");
    c_skip: cover property (skip);
    c_refused: cover property (op_valid && !ready);
    c_sub: cover property (take && op_code == op_subtract_with_borrow_to_mem);
endmodule
bind aao_alu_core aao_alu_core_sva u_sva (.clk(clk), .rst(rst), .op_valid(op_valid),
    .op_code(op_code), .mem_rdata(mem_rdata), .imm_data(imm_data), .bit_sel(bit_sel),
    .ready(ready), .done(done), .acc(acc), .flag_c(flag_c), .flag_ac(flag_ac),
    .flag_z(flag_z), .flag_ov(flag_ov), .mem_wr(mem_wr), .mem_wdata(mem_wdata), .skip(skip));
`default_nettype wire

// ===== verification/tb_accumulator_alu_ops.sv
// Self-checking testbench of the ALU operation core
`timescale 1ns/100ps
`default_nettype none
module tb_accumulator_alu_ops
    import aao_pkg::*;
;
    logic clk, rst, op_valid, ready, done, flag_c, flag_ac, flag_z, flag_ov, mem_wr, skip;
    aao_op_t op_code;
    logic [7:0] mem_rdata, imm_data, acc, mem_wdata;
    logic [2:0] bit_sel;
    logic [7:0] e_acc, e_wd;
    logic e_c, e_ac, e_z, e_ov, x_done, x_wr, x_skip;
    int mismatches, n_compared;
    aao_alu_core dut (.clk(clk), .rst(rst), .op_valid(op_valid), .op_code(op_code),
        .mem_rdata(mem_rdata), .imm_data(imm_data), .bit_sel(bit_sel), .ready(ready),
        .done(done), .acc(acc), .flag_c(flag_c), .flag_ac(flag_ac), .flag_z(flag_z),
        .flag_ov(flag_ov), .mem_wr(mem_wr), .mem_wdata(mem_wdata), .skip(skip));
    ////////////////////////////////////////////////////////////////////////
    task automatic step();
        @(posedge clk);
        #1;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            mismatches++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic check_out();
        chk(acc, e_acc);
        chk({4'h0, flag_c, flag_ac, flag_z, flag_ov}, {4'h0, e_c, e_ac, e_z, e_ov});
        chk({4'h0, done, mem_wr, skip, ready}, {4'h0, x_done, x_wr, x_skip, !x_skip});
        chk(mem_wdata, e_wd);
    endtask
    // Reference of one operation, updates expected state
    task automatic predict(input aao_op_t code, input logic [7:0] m, input logic [7:0] imm,
        input logic [2:0] bs);
        logic [7:0] b;
        logic bw;
        logic [8:0] t;
        logic [4:0] h;
        logic [3:0] sf;
        b = (code == op_subtract_immediate) ? imm : m;
        bw = (code == op_subtract_with_borrow || code == op_subtract_with_borrow_to_mem) & !e_c;
        t = {1'b0, e_acc} - {1'b0, b} - {8'h00, bw};
        h = {1'b0, e_acc[3:0]} - {1'b0, b[3:0]} - {4'h0, bw};
        sf = {!t[8], !h[4], t[7:0] == 8'h00, (e_acc[7] ^ b[7]) & (e_acc[7] ^ t[7])};
        x_done = 1'b1;
        x_wr = 1'b0;
        x_skip = 1'b0;
        case (code)
            op_rotate_left_to_acc: e_acc = {m[6:0], m[7]};
            op_rotate_left_thru_carry: {x_wr, e_wd, e_c} = {1'b1, m[6:0], e_c, m[7]};
            op_rotate_left_thru_carry_to_acc: {e_acc, e_c} = {m[6:0], e_c, m[7]};
            op_rotate_right_in_place: {x_wr, e_wd} = {1'b1, m[0], m[7:1]};
            op_rotate_right_to_acc: e_acc = {m[0], m[7:1]};
            op_rotate_right_thru_carry: {x_wr, e_wd, e_c} = {1'b1, e_c, m[7:1], m[0]};
            op_rotate_right_thru_carry_to_acc: {e_acc, e_c} = {e_c, m[7:1], m[0]};
            op_subtract_with_borrow, op_subtract_to_acc, op_subtract_immediate: e_acc = t[7:0];
            op_subtract_with_borrow_to_mem, op_minus_memory_into_memory: {x_wr, e_wd} = t;
            op_decrement_skip_if_zero: {x_wr, e_wd, x_skip} = {1'b1, m - 8'h01, m == 8'h01};
            op_decrement_to_acc_skip_if_zero: {e_acc, x_skip} = {m - 8'h01, m == 8'h01};
            op_increment_skip_if_zero: {x_wr, e_wd, x_skip} = {1'b1, m + 8'h01, m == 8'hff};
            op_increment_to_acc_skip_if_zero: {e_acc, x_skip} = {m + 8'h01, m == 8'hff};
            op_skip_if_bit_set: x_skip = m[bs];
            op_skip_if_memory_zero: x_skip = (m == 8'h00);
            op_byte_set: {x_wr, e_wd} = {1'b1, 8'hff};
            op_bit_set: {x_wr, e_wd} = {1'b1, m | (8'h01 << bs)};
            op_nibble_exchange_in_place: {x_wr, e_wd} = {1'b1, m[3:0], m[7:4]};
            op_nibble_exchange_to_acc: e_acc = {m[3:0], m[7:4]};
            op_load_acc: e_acc = imm;
            op_load_carry: e_c = imm[0];
            default: x_done = 1'b0;
        endcase
        if (code >= op_subtract_with_borrow && code <= op_subtract_immediate)
            {e_c, e_ac, e_z, e_ov} = sf;
        if (code == op_minus_memory_into_memory || code == op_subtract_with_borrow_to_mem)
            x_wr = 1'b1;
    endtask
    task automatic drive(input aao_op_t code, input logic [7:0] m, input logic [7:0] imm,
        input logic [2:0] bs);
        op_valid = 1'b1;
        op_code = code;
        mem_rdata = m;
        imm_data = imm;
        bit_sel = bs;
    endtask
    task automatic op(input aao_op_t code, input logic [7:0] m, input logic [7:0] imm,
        input logic [2:0] bs);
        predict(code, m, imm, bs);
        step();
        drive(code, m, imm, bs);
        step();
        op_valid = 1'b0;
        mem_rdata = ~m;
        check_out();
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        chk({4'h0, done, mem_wr, skip, ready}, 8'h01);
        chk(acc | mem_wdata | {4'h0, flag_c, flag_ac, flag_z, flag_ov}, 8'h00);
        $display("test reset done");
    endtask
    task automatic t_rotates();
        op(op_load_carry, 8'h00, 8'h01, 3'h0);
        op(op_rotate_left_to_acc, 8'h81, 8'h00, 3'h0);
        op(op_rotate_left_thru_carry, 8'h40, 8'h00, 3'h0);
        op(op_rotate_left_thru_carry_to_acc, 8'h80, 8'h00, 3'h0);
        op(op_rotate_right_in_place, 8'h01, 8'h00, 3'h0);
        op(op_rotate_right_to_acc, 8'h02, 8'h00, 3'h0);
        op(op_rotate_right_thru_carry, 8'h02, 8'h00, 3'h0);
        op(op_rotate_right_thru_carry_to_acc, 8'h01, 8'h00, 3'h0);
        $display("test rotates done");
    endtask
    task automatic t_subtract();
        op(op_load_acc, 8'h00, 8'h10, 3'h0);
        op(op_subtract_to_acc, 8'h10, 8'h00, 3'h0);
        op(op_subtract_to_acc, 8'h01, 8'h00, 3'h0);
        op(op_subtract_with_borrow, 8'h0f, 8'h00, 3'h0);
        op(op_subtract_with_borrow_to_mem, 8'h70, 8'h00, 3'h0);
        op(op_minus_memory_into_memory, 8'h01, 8'h00, 3'h0);
        op(op_load_acc, 8'h00, 8'h80, 3'h0);
        op(op_subtract_immediate, 8'h00, 8'h01, 3'h0);
        $display("test subtract done");
    endtask
    task automatic t_incdec();
        op(op_decrement_skip_if_zero, 8'h01, 8'h00, 3'h0);
        op(op_decrement_skip_if_zero, 8'h00, 8'h00, 3'h0);
        op(op_decrement_to_acc_skip_if_zero, 8'h01, 8'h00, 3'h0);
        op(op_decrement_to_acc_skip_if_zero, 8'h80, 8'h00, 3'h0);
        op(op_increment_skip_if_zero, 8'hff, 8'h00, 3'h0);
        op(op_increment_skip_if_zero, 8'h7f, 8'h00, 3'h0);
        op(op_increment_to_acc_skip_if_zero, 8'hff, 8'h00, 3'h0);
        op(op_increment_to_acc_skip_if_zero, 8'h00, 8'h00, 3'h0);
        $display("test incdec done");
    endtask
    task automatic t_tests();
        for (int i = 0; i < 8; i++)
        begin
            op(op_skip_if_bit_set, 8'h01 << i, 8'h00, 3'(i));
            op(op_skip_if_bit_set, ~(8'h01 << i), 8'h00, 3'(i));
            op(op_bit_set, 8'h5a, 8'h00, 3'(i));
        end
        op(op_skip_if_memory_zero, 8'h00, 8'h00, 3'h0);
        op(op_skip_if_memory_zero, 8'h80, 8'h00, 3'h0);
        op(aao_op_t'(5'h18), 8'h00, 8'h00, 3'h0);
        op(op_byte_set, 8'h12, 8'h00, 3'h0);
        op(op_nibble_exchange_in_place, 8'h1e, 8'h00, 3'h0);
        op(op_nibble_exchange_to_acc, 8'ha5, 8'h00, 3'h0);
        $display("test bit byte done");
    endtask
    // Request held through the dummy cycle must wait one edge
    task automatic t_back_to_back();
        predict(op_increment_skip_if_zero, 8'hff, 8'h00, 3'h0);
        step();
        drive(op_increment_skip_if_zero, 8'hff, 8'h00, 3'h0);
        step();
        check_out();
        predict(op_load_acc, 8'h00, 8'h5a, 3'h0);
        drive(op_load_acc, 8'h00, 8'h5a, 3'h0);
        step();
        chk({7'h0, done}, 8'h00);
        step();
        check_out();
        predict(op_subtract_immediate, 8'h00, 8'h5b, 3'h0);
        drive(op_subtract_immediate, 8'h00, 8'h5b, 3'h0);
        step();
        op_valid = 1'b0;
        check_out();
        $display("test back to back done");
    endtask
    task automatic conclude();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial
    begin
        #20000;
        mismatches++;
        $display("watchdog expired");
        conclude();
    end
    initial
    begin
        {rst, op_valid, mem_rdata, imm_data, bit_sel} = {1'b1, 1'b0, 8'h00, 8'h00, 3'h0};
        op_code = op_load_acc;
        {e_acc, e_wd, e_c, e_ac, e_z, e_ov} = '0;
        mismatches = 0;
        n_compared = 0;
        repeat (6) step();
        t_reset();
        rst = 1'b0;
        t_rotates();
        t_subtract();
        t_incdec();
        t_tests();
        t_back_to_back();
        conclude();
    end
endmodule
`default_nettype wire
